// file: logic/gpm_pkg.sv
package gpm_pkg;
	// ==========================================================
	// Register map; config index 0x201 is a word index, shifted to byte address 0x804
	localparam logic [11:0] GPM_CFG_INDEX = 12'h201;
	localparam logic [11:0] GPM_CFG_ADDR = {GPM_CFG_INDEX[9:0], 2'b00};
	localparam logic [11:0] GPM_IRQ_STATUS_ADDR = 12'h000;
	localparam logic [11:0] GPM_IRQ_MASK_ADDR = 12'h004;
	localparam logic [11:0] GPM_PIN_STATE_ADDR = 12'h008;
	// ==========================================================
	// Field layout of the pin configuration register
	localparam int GPM_INVERT_BIT = 10;
	localparam int GPM_LEVEL_BIT = 6;
	localparam int GPM_FSEL_LSB = 0;
	localparam int GPM_FSEL_W = 5;
	localparam logic [15:0] GPM_CFG_RESET = 16'h0000;
	localparam logic [4:0] GPM_FSEL_RESET = 5'h00;
	// ==========================================================
	// Function select codes
	localparam logic [4:0] GPM_FN_CLOCK_OUTPUT = 5'h00;
	localparam logic [4:0] GPM_FN_LEVEL = 5'h01;
	localparam logic [4:0] GPM_FN_SERIAL_AUDIO = 5'h02;
	localparam logic [4:0] GPM_FN_IRQ = 5'h03;
	localparam logic [4:0] GPM_FN_THERMAL = 5'h04;
	localparam logic [4:0] GPM_FN_SECOND_PLL_LOCK = 5'h06;
	localparam logic [4:0] GPM_FN_THIRD_PLL_LOCK = 5'h07;
	localparam logic [4:0] GPM_FN_FREQ_LOOP_LOCK = 5'h09;
	localparam logic [4:0] GPM_FN_DYN_RANGE_ACT = 5'h0a;
	localparam logic [4:0] GPM_FN_SEQ_DONE = 5'h0b;
	localparam logic [4:0] GPM_FN_LEVEL_CTRL_NG = 5'h0c;
	localparam logic [4:0] GPM_FN_LEVEL_CTRL_PEAK = 5'h0d;
	localparam logic [4:0] GPM_FN_LEVEL_CTRL_SAT = 5'h0e;
	localparam logic [4:0] GPM_FN_LEVEL_CTRL_THR = 5'h0f;
	localparam logic [4:0] GPM_FN_LEVEL_CTRL_LOCK = 5'h10;
	localparam logic [4:0] GPM_FN_BUF_ERR = 5'h11;
	localparam logic [4:0] GPM_FN_GEN_CLK = 5'h12;
	localparam logic [4:0] GPM_FN_DMIC_CLK = 5'h13;
	localparam logic [4:0] GPM_FN_MIC_DET = 5'h15;
	localparam logic [4:0] GPM_FN_MIC_SHORT = 5'h16;
	// ==========================================================
	// Interrupt bits: pin rise, pin fall, reserved code written
	localparam int GPM_IRQ_W = 3;
	localparam int GPM_IRQ_RISE = 0;
	localparam int GPM_IRQ_FALL = 1;
	localparam int GPM_IRQ_RSVD = 2;
	localparam logic [2:0] GPM_IRQ_RESET = 3'h0;
	localparam int GPM_SOURCES = 32;
endpackage

// file: logic/gpm_sync2.sv
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser, one per bit
module gpm_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_bad_width
		$error("gpm_sync2: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // gpm_sync2

// file: logic/gpm_mux.sv
`timescale 1ns/1ps
// ==========================================================
// Function selection and polarity stage
module gpm_mux
	import gpm_pkg::*;
#(
	parameter int SEL_W = 5
) (
	input wire logic [GPM_SOURCES-1:0] sources_in,
	input wire logic [SEL_W-1:0] select_in,
	input wire logic invert_in,
	output logic selected_out,
	output logic pin_level_out
);
	if (SEL_W != GPM_FSEL_W || (1 << SEL_W) != GPM_SOURCES) begin : g_bad_sel
		$error("gpm_mux: SEL_W must match the select field");
	end

	wire logic picked;
	assign picked = sources_in[select_in];
	assign selected_out = picked;
	// Inversion after the mux, whatever is routed
	assign pin_level_out = picked ^ invert_in;
endmodule // gpm_mux

// file: logic/gpm_top.sv
`timescale 1ns/1ps
module gpm_top
	import gpm_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Routed internal signals (clocks arrive as plain levels)
	input wire logic clock_output_in,
	input wire logic serial_audio_out_in,
	input wire logic irq_request_in,
	input wire logic thermal_shutdown_in,
	input wire logic second_pll_lock_in,
	input wire logic third_pll_lock_in,
	input wire logic frequency_locked_loop_lock_in,
	input wire logic dynamic_range_controller_active_in,
	input wire logic write_sequencer_done_in,
	input wire logic automatic_level_control_noise_gate_in,
	input wire logic automatic_level_control_peak_overload_in,
	input wire logic automatic_level_control_saturation_in,
	input wire logic automatic_level_control_threshold_in,
	input wire logic automatic_level_control_level_lock_in,
	input wire logic buffer_error_in,
	input wire logic general_output_clock_in,
	input wire logic dmic_clock_in,
	input wire logic mic_detect_in,
	input wire logic mic_short_in,
	// Pin and interrupt
	output logic pin2_out,
	output logic pin2_oe_out,
	output logic irq_out
);
	// ==========================================================
	// Input synchronisation
	localparam int NSRC = 19;
	wire logic [NSRC-1:0] raw_src;
	wire logic [NSRC-1:0] sync_src;

	assign raw_src = {mic_short_in, mic_detect_in, dmic_clock_in,
		general_output_clock_in, buffer_error_in,
		automatic_level_control_level_lock_in,
		automatic_level_control_threshold_in,
		automatic_level_control_saturation_in,
		automatic_level_control_peak_overload_in,
		automatic_level_control_noise_gate_in, write_sequencer_done_in,
		dynamic_range_controller_active_in,
		frequency_locked_loop_lock_in, third_pll_lock_in,
		second_pll_lock_in, thermal_shutdown_in, irq_request_in,
		serial_audio_out_in, clock_output_in};

	// Sources come from other blocks and clocks, so all are resynchronised
	gpm_sync2 #(
		.WIDTH(NSRC)
	) u_sync (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.async_in(raw_src),
		.sync_out(sync_src)
	);

	// ==========================================================
	// Configuration registers
	logic pin2_invert_q;
	logic pin2_static_level_q;
	logic [4:0] pin2_function_select_q;
	logic [GPM_IRQ_W-1:0] irq_status_q;
	logic [GPM_IRQ_W-1:0] irq_status_d;
	logic [GPM_IRQ_W-1:0] irq_mask_q;
	logic pin_q;
	logic pin_prev_q;

	// ==========================================================
	// APB decode
	wire logic access;
	wire logic wr_en;
	wire logic hit_cfg;
	wire logic hit_sts;
	wire logic hit_msk;
	wire logic hit_pin;
	wire logic hit_any;
	wire logic wr_cfg;
	wire logic wr_cfg_lo;
	wire logic wr_cfg_hi;

	assign access = psel_in & penable_in;
	assign wr_en = access & pwrite_in;
	assign hit_cfg = paddr_in == GPM_CFG_ADDR;
	assign hit_sts = paddr_in == GPM_IRQ_STATUS_ADDR;
	assign hit_msk = paddr_in == GPM_IRQ_MASK_ADDR;
	assign hit_pin = paddr_in == GPM_PIN_STATE_ADDR;
	assign hit_any = hit_cfg | hit_sts | hit_msk | hit_pin;
	assign wr_cfg = wr_en & hit_cfg;
	assign wr_cfg_lo = wr_cfg & pstrb_in[0];
	assign wr_cfg_hi = wr_cfg & pstrb_in[1];

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~hit_any;

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pin2_function_select_q <= GPM_FSEL_RESET;
			pin2_static_level_q <= GPM_CFG_RESET[GPM_LEVEL_BIT];
		end else if (wr_cfg_lo) begin
			pin2_function_select_q <=
				pwdata_in[GPM_FSEL_LSB +: GPM_FSEL_W];
			pin2_static_level_q <= pwdata_in[GPM_LEVEL_BIT];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pin2_invert_q <= GPM_CFG_RESET[GPM_INVERT_BIT];
		end else if (wr_cfg_hi) begin
			pin2_invert_q <= pwdata_in[GPM_INVERT_BIT];
		end
	end

	// ==========================================================
	// Source table indexed by function select
	logic [GPM_SOURCES-1:0] src_table;

	always_comb begin
		src_table = '0;
		src_table[GPM_FN_CLOCK_OUTPUT] = sync_src[0];
		src_table[GPM_FN_LEVEL] = pin2_static_level_q;
		src_table[GPM_FN_SERIAL_AUDIO] = sync_src[1];
		src_table[GPM_FN_IRQ] = sync_src[2];
		src_table[GPM_FN_THERMAL] = sync_src[3];
		src_table[GPM_FN_SECOND_PLL_LOCK] = sync_src[4];
		src_table[GPM_FN_THIRD_PLL_LOCK] = sync_src[5];
		src_table[GPM_FN_FREQ_LOOP_LOCK] = sync_src[6];
		src_table[GPM_FN_DYN_RANGE_ACT] = sync_src[7];
		src_table[GPM_FN_SEQ_DONE] = sync_src[8];
		src_table[GPM_FN_LEVEL_CTRL_NG] = sync_src[9];
		src_table[GPM_FN_LEVEL_CTRL_PEAK] = sync_src[10];
		src_table[GPM_FN_LEVEL_CTRL_SAT] = sync_src[11];
		src_table[GPM_FN_LEVEL_CTRL_THR] = sync_src[12];
		src_table[GPM_FN_LEVEL_CTRL_LOCK] = sync_src[13];
		src_table[GPM_FN_BUF_ERR] = sync_src[14];
		src_table[GPM_FN_GEN_CLK] = sync_src[15];
		src_table[GPM_FN_DMIC_CLK] = sync_src[16];
		src_table[GPM_FN_MIC_DET] = sync_src[17];
		src_table[GPM_FN_MIC_SHORT] = sync_src[18];
		// Reserved codes see logic low before inversion
	end

	wire logic pin_level;

	gpm_mux #(
		.SEL_W(GPM_FSEL_W)
	) u_mux (
		.sources_in(src_table),
		.select_in(pin2_function_select_q),
		.invert_in(pin2_invert_q),
		.selected_out(),
		.pin_level_out(pin_level)
	);

	// Registered pin so the output never glitches across the mux
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pin_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_q <= pin_level;
			pin_prev_q <= pin_q;
		end
	end

	assign pin2_out = pin_q;
	assign pin2_oe_out = 1'b1;

	// ==========================================================
	// Interrupts: sticky, write one to clear, set beats clear
	wire logic [GPM_IRQ_W-1:0] irq_event;
	wire logic [GPM_IRQ_W-1:0] irq_clear;
	wire logic rsvd_code;
	wire logic [4:0] new_fsel;

	assign new_fsel = pwdata_in[GPM_FSEL_LSB +: GPM_FSEL_W];
	assign rsvd_code = new_fsel == 5'h05 || new_fsel == 5'h08
		|| new_fsel == 5'h14 || new_fsel >= 5'h17;
	assign irq_event[GPM_IRQ_RISE] = pin_q & ~pin_prev_q;
	assign irq_event[GPM_IRQ_FALL] = ~pin_q & pin_prev_q;
	assign irq_event[GPM_IRQ_RSVD] = wr_cfg_lo & rsvd_code;
	assign irq_clear = (wr_en & hit_sts & pstrb_in[0])
		? pwdata_in[GPM_IRQ_W-1:0] : '0;

	always_comb begin
		irq_status_d = (irq_status_q & ~irq_clear) | irq_event;
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			irq_status_q <= GPM_IRQ_RESET;
			irq_mask_q <= GPM_IRQ_RESET;
		end else begin
			irq_status_q <= irq_status_d;
			if (wr_en && hit_msk && pstrb_in[0]) begin
				irq_mask_q <= pwdata_in[GPM_IRQ_W-1:0];
			end
		end
	end

	assign irq_out = |(irq_status_q & irq_mask_q);

	// ==========================================================
	// Read data; level bit reads zero as it is write-only
	logic [31:0] rdata;

	always_comb begin
		rdata = '0;
		if (hit_cfg) begin
			rdata[GPM_INVERT_BIT] = pin2_invert_q;
			rdata[GPM_FSEL_LSB +: GPM_FSEL_W] = pin2_function_select_q;
			// Level bit left at zero: write-only
		end else if (hit_sts) begin
			rdata[GPM_IRQ_W-1:0] = irq_status_q;
		end else if (hit_msk) begin
			rdata[GPM_IRQ_W-1:0] = irq_mask_q;
		end else if (hit_pin) begin
			rdata[0] = pin_q;
		end
	end

	assign prdata_out = (access && !pwrite_in) ? rdata : '0;
endmodule // gpm_top

// file: verif/gpm_monitor.sv
`timescale 1ns/1ps
// ========
// Port checker; config and mask are shadowed from APB writes
module gpm_monitor
	import gpm_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic clock_output_in,
	input wire logic irq_request_in,
	input wire logic pin2_out,
	input wire logic pin2_oe_out,
	input wire logic irq_out
);
	logic [15:0] cfg_q;
	logic [2:0] mask_q;
	logic [2:0] up_q;
	wire wr = psel_in & penable_in & pwrite_in;
	wire is_cfg = paddr_in == GPM_CFG_ADDR;
	wire is_msk = paddr_in == GPM_IRQ_MASK_ADDR;
	wire mapped = is_cfg | is_msk | paddr_in == GPM_IRQ_STATUS_ADDR |
		paddr_in == GPM_PIN_STATE_ADDR;
	// Source checks wait out the two sync flops after reset
	wire live = up_q == 3'h4;
	wire inv = cfg_q[GPM_INVERT_BIT];
	wire [4:0] sel = cfg_q[4:0];
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			cfg_q <= GPM_CFG_RESET;
			mask_q <= GPM_IRQ_RESET;
			up_q <= 3'h0;
		end else begin
			if (!live)
				up_q <= up_q + 3'h1;
			if (wr && is_cfg && pstrb_in[0])
				cfg_q[7:0] <= pwdata_in[7:0];
			if (wr && is_cfg && pstrb_in[1])
				cfg_q[15:8] <= pwdata_in[15:8];
			if (wr && is_msk && pstrb_in[0])
				mask_q <= pwdata_in[2:0];
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	sequence apb_access;
		psel_in && penable_in;
	endsequence
	sequence cfg_settled;
		live && $stable(cfg_q);
	endsequence
	chk_zero_wait: assert property (apb_access |-> pready_out)
		else $error("pready low in access phase");
	chk_bad_addr: assert property (apb_access |-> pslverr_out == !mapped)
		else $error("pslverr does not match decode");
	chk_unmapped_zero: assert property (apb_access ##0 (!pwrite_in &&
		!mapped) |-> prdata_out == 32'h0)
		else $error("unmapped read not zero");
	chk_cfg_readback: assert property (apb_access ##0 (!pwrite_in &&
		is_cfg) |-> prdata_out[4:0] == sel && prdata_out[10] == inv)
		else $error("config readback wrong");
	chk_reset_low: assert property ($fell(reset_in) |-> !pin2_out && !irq_out)
		else $error("pin or irq high after reset");
	chk_level_drive: assert property (cfg_settled ##0
		sel == GPM_FN_LEVEL |-> pin2_out == (cfg_q[GPM_LEVEL_BIT] ^ inv))
		else $error("static level wrong");
	chk_clock_route: assert property (cfg_settled ##0
		sel == GPM_FN_CLOCK_OUTPUT |->
		pin2_out == ($past(clock_output_in, 3) ^ inv))
		else $error("clock output not routed");
	chk_irq_route: assert property (cfg_settled ##0
		sel == GPM_FN_IRQ |-> pin2_out == ($past(irq_request_in, 3) ^ inv))
		else $error("interrupt request not routed");
	chk_masked_quiet: assert property (mask_q == 3'h0 |-> !irq_out)
		else $error("irq high with all masked");
	chk_pin_driven: assert property (live |-> pin2_oe_out)
		else $error("pin not driven");
endmodule // gpm_monitor

bind gpm_top gpm_monitor gpm_monitor_i (.mclk_in, .reset_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
	.pready_out, .pslverr_out, .clock_output_in, .irq_request_in, .pin2_out,
	.pin2_oe_out, .irq_out);

// file: verif/gpm_board.sv
`timescale 1ns/1ps
// ========
// Board side: samples the pin each clock; assumed pull-up when undriven
module gpm_board (
	input wire logic mclk_in,
	input wire logic pin_in,
	input wire logic oe_in,
	output logic seen_out
);
	always_ff @(posedge mclk_in)
		seen_out <= oe_in ? pin_in : 1'b1;
endmodule // gpm_board

// file: verif/gpm_top_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module gpm_top_test
	import gpm_pkg::*;
;
	logic mclk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0;
	logic pwrite_in = 0, pready_out, pslverr_out, pin, oe, irq_out, seen;
	logic [11:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0, prdata_out, rd_v, e_v, exp_q[$];
	logic [3:0] pstrb_in = 4'hf;
	logic [18:0] src = '0;
	int n_fail = 0, check_count = 0;
	event rd_done, pin_done;
	localparam logic [4:0] FN [19] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h06,
		5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
		5'h11, 5'h12, 5'h13, 5'h15, 5'h16};
	initial forever #2 mclk_in = ~mclk_in;
	gpm_top gpm_top_i (.mclk_in, .reset_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
		.pready_out, .pslverr_out, .clock_output_in(src[0]),
		.serial_audio_out_in(src[1]), .irq_request_in(src[2]),
		.thermal_shutdown_in(src[3]), .second_pll_lock_in(src[4]),
		.third_pll_lock_in(src[5]),
		.frequency_locked_loop_lock_in(src[6]),
		.dynamic_range_controller_active_in(src[7]),
		.write_sequencer_done_in(src[8]),
		.automatic_level_control_noise_gate_in(src[9]),
		.automatic_level_control_peak_overload_in(src[10]),
		.automatic_level_control_saturation_in(src[11]),
		.automatic_level_control_threshold_in(src[12]),
		.automatic_level_control_level_lock_in(src[13]),
		.buffer_error_in(src[14]), .general_output_clock_in(src[15]),
		.dmic_clock_in(src[16]), .mic_detect_in(src[17]),
		.mic_short_in(src[18]), .pin2_out(pin), .pin2_oe_out(oe), .irq_out);
	gpm_board gpm_board_i (.mclk_in, .pin_in(pin), .oe_in(oe),
		.seen_out(seen));
	// ========
	// Watcher: oldest note against what appeared
	always @(rd_done) begin
		e_v = exp_q.pop_front();
		`CHK(rd_v, e_v)
	end
	always @(pin_done) begin
		e_v = exp_q.pop_front();
		`CHK({30'h0, irq_out, seen}, e_v)
	end
	task stop_test;
		// Let the watchers take the last note first
		@(posedge mclk_in);
		$display("errors %0d of %0d checks", n_fail, check_count);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ========
	// APB master; idle edge first so strobes never change twice at once
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1;
		for (i = 0; i < 8; i++) begin
			@(posedge mclk_in);
			if (pready_out === 1'b1)
				break;
		end
		if (i == 8) begin
			n_fail++;
			stop_test;
		end
		// Level bit is write-only and reads zero; it is masked anyway
		rd_v = prdata_out & ~32'h40;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task expect_rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		exp_q.push_back(e);
		->rd_done;
	endtask
	task look(input logic [1:0] e);
		repeat (5) @(posedge mclk_in);
		exp_q.push_back({30'h0, e});
		->pin_done;
	endtask
	function automatic logic pin_exp(logic [4:0] c, logic l, logic v);
		pin_exp = v;
		if (c == GPM_FN_LEVEL)
			pin_exp = l ^ v;
		for (int k = 0; k < 19; k++)
			if (FN[k] == c)
				pin_exp = src[k] ^ v;
	endfunction
	initial begin
		logic [4:0] c;
		logic v, l;
		void'($urandom(17));
		repeat (16) @(posedge mclk_in);
		reset_in <= 0;
		expect_rd(GPM_CFG_ADDR, 32'h0);
		look(2'b00);
		// Reserved codes too, written on purpose
		for (int i = 0; i < 32; i++) begin
			c = i[4:0];
			{v, l} = 2'($urandom);
			src <= 19'($urandom);
			apb(1, GPM_CFG_ADDR, {21'h0, v, 3'h0, l, 1'b0, c});
			look({1'b0, pin_exp(c, l, v)});
			expect_rd(GPM_CFG_ADDR, {21'h0, v, 5'h0, c});
		end
		apb(1, GPM_CFG_ADDR, 32'h1);
		look(2'b00);
		apb(1, GPM_IRQ_STATUS_ADDR, 32'h7);
		expect_rd(GPM_IRQ_STATUS_ADDR, 32'h0);
		apb(1, GPM_CFG_ADDR, 32'h41);
		look(2'b01);
		apb(1, GPM_IRQ_MASK_ADDR, 32'h1);
		look(2'b11);
		expect_rd(GPM_IRQ_STATUS_ADDR, 32'h1);
		apb(1, GPM_IRQ_STATUS_ADDR, 32'h1);
		look(2'b01);
		apb(1, 12'hffc, 32'h3);
		expect_rd(12'hffc, 32'h0);
		expect_rd(GPM_CFG_ADDR, 32'h1);
		expect_rd(GPM_PIN_STATE_ADDR, 32'h1);
		// Reserved code: pin falls, fall and reserved flags set
		apb(1, GPM_CFG_ADDR, 32'h5);
		look(2'b00);
		expect_rd(GPM_IRQ_STATUS_ADDR, 32'h6);
		expect_rd(GPM_PIN_STATE_ADDR, 32'h0);
		// Low byte only: invert in byte one must stay clear
		pstrb_in <= 4'h1;
		apb(1, GPM_CFG_ADDR, 32'h400);
		pstrb_in <= 4'hf;
		expect_rd(GPM_CFG_ADDR, 32'h0);
		stop_test;
	end
endmodule // gpm_top_test
